// [hw/laser_dac_lut_config_regs.sv]
/*
 Register bank for mode, temperature index, DAC values, configuration,
 RSSI warning masks and the two DAC lookup tables.
 Assumes requests arrive synchronous to clk_in, one per cycle at most;
 conversion completion and temperature index come from the ADC logic.
*/
`timescale 1ns/10ps
module laser_dac_lut_config_regs (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire laser_cfg_pkg::reg_req_s req_in,
    input wire laser_cfg_pkg::rssi_warn_s rssi_warn_in,
    input wire logic other_irq_in,
    input wire logic alt_mask_sel_in,
    input wire logic [7:0] alt_rssi_mask_in,
    input wire logic hw_in_status_in,
    input wire logic conv_done_in,
    input wire logic [7:0] conv_index_in,
    output logic [7:0] rdata_out,
    output logic rvalid_out,
    output logic module_irq_status_out,
    output logic [7:0] bias_dac_out,
    output logic bias_dac_oe_out,
    output logic [7:0] mod_dac_out,
    output logic mod_dac_oe_out,
    output logic bias_dac_range_out,
    output logic mod_dac_range_out,
    output logic gp_output_pin_out,
    output logic fast_trip_en_out,
    output logic shadow_volatile_out,
    output logic temp_conv_en_out,
    output logic trip_flag_latch_en_out,
    output logic alarm_latch_en_out,
    output logic warn_latch_en_out
);
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic hit(input laser_cfg_pkg::reg_req_s r,
                                 input logic [2:0] t, input logic [7:0] o);
        hit = (r.table_sel == t) && (r.offset == o);
    endfunction

    function automatic logic lut_hit(input laser_cfg_pkg::reg_req_s r,
                                     input logic [2:0] t);
        lut_hit = (r.table_sel == t) && (r.offset >= laser_cfg_pkg::OFS_LUT_FIRST)
            && (r.offset <= laser_cfg_pkg::OFS_LUT_LAST);
    endfunction

    function automatic logic [6:0] clamp_index(input logic [7:0] i);
        clamp_index = (i > laser_cfg_pkg::INDEX_MAX) ?
            laser_cfg_pkg::INDEX_MAX[6:0] : i[6:0];
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [7:0] mode_r, mode_nxt;
    logic [7:0] index_r, index_nxt;
    logic [7:0] bias_r, bias_nxt;
    logic [7:0] mod_r, mod_nxt;
    logic bias_oe_r, bias_oe_nxt;
    logic mod_oe_r, mod_oe_nxt;
    logic [7:0] config_r, config_nxt;
    logic [7:0] mask_r, mask_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic rvalid_r, rvalid_nxt;
    logic irq_r, irq_nxt;
    logic gp_r, gp_nxt;
    localparam int LUT_DEPTH_L = laser_cfg_pkg::LUT_DEPTH;
    logic [7:0] bias_lut [LUT_DEPTH_L];
    logic [7:0] mod_lut [LUT_DEPTH_L];
    logic bias_lut_we;
    logic mod_lut_we;
    logic [6:0] lut_addr;
    logic [6:0] sel_addr;
    logic auto_load;
    logic [7:0] eff_mask;

    assign lut_addr = 7'(req_in.offset - laser_cfg_pkg::OFS_LUT_FIRST);
    assign sel_addr = clamp_index(index_r); // R24 R23
    assign auto_load = mode_r[laser_cfg_pkg::MODE_TEMP_CONV]; // R11

    // ----------------------------------------------------------------
    // Lookup tables
    // ----------------------------------------------------------------
    always_comb begin
        bias_lut_we = req_in.wr && lut_hit(req_in, laser_cfg_pkg::TBL_BIAS_LUT); // R05
        mod_lut_we = req_in.wr && lut_hit(req_in, laser_cfg_pkg::TBL_MOD_LUT); // R06
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < LUT_DEPTH_L; i++) begin
                bias_lut[i] <= laser_cfg_pkg::LUT_RESET; // R05
                mod_lut[i] <= laser_cfg_pkg::LUT_RESET; // R06
            end
        end else begin
            if (bias_lut_we) begin
                bias_lut[lut_addr] <= req_in.wdata; // R05
            end
            if (mod_lut_we) begin
                mod_lut[lut_addr] <= req_in.wdata; // R06
            end
        end
    end

    // ----------------------------------------------------------------
    // Register next state
    // ----------------------------------------------------------------
    always_comb begin
        mode_nxt = mode_r;
        index_nxt = index_r;
        bias_nxt = bias_r;
        mod_nxt = mod_r;
        bias_oe_nxt = bias_oe_r;
        mod_oe_nxt = mod_oe_r;
        config_nxt = config_r;
        mask_nxt = mask_r;
        if (req_in.wr && hit(req_in, laser_cfg_pkg::TBL_CTRL, laser_cfg_pkg::OFS_MODE)) begin
            mode_nxt = req_in.wdata & laser_cfg_pkg::MODE_WR_MASK; // R07
        end
        if (req_in.wr && hit(req_in, laser_cfg_pkg::TBL_CTRL, laser_cfg_pkg::OFS_CONFIG)) begin
            config_nxt = req_in.wdata & laser_cfg_pkg::CONFIG_WR_MASK; // R17
        end
        if (req_in.wr && hit(req_in, laser_cfg_pkg::TBL_MASKS,
                             laser_cfg_pkg::OFS_RSSI_WARN_MASK)) begin
            mask_nxt = req_in.wdata & laser_cfg_pkg::MASK_WR_MASK; // R02
        end
        // Index: automatic from conversion or host in test mode
        if (mode_r[laser_cfg_pkg::MODE_AUTO_INDEX]) begin
            if (auto_load && conv_done_in) begin
                index_nxt = {1'b0, clamp_index(conv_index_in)}; // R12 R13 R24
            end
        end else if (req_in.wr && hit(req_in, laser_cfg_pkg::TBL_CTRL,
                                      laser_cfg_pkg::OFS_TEMP_INDEX)) begin
            index_nxt = {1'b0, clamp_index(req_in.wdata)}; // R12 R24
        end
        // DAC values: table refresh in auto mode, host writes otherwise
        if (auto_load) begin
            if (conv_done_in || bias_oe_r) begin
                bias_nxt = bias_lut[sel_addr]; // R16 R23
                mod_nxt = mod_lut[sel_addr]; // R16 R23
            end
            if (conv_done_in) begin
                bias_oe_nxt = 1'b1; // R14
                mod_oe_nxt = 1'b1; // R15
            end
        end else begin
            if (req_in.wr && hit(req_in, laser_cfg_pkg::TBL_CTRL,
                                 laser_cfg_pkg::OFS_BIAS_DAC)) begin
                bias_nxt = req_in.wdata; // R10
                bias_oe_nxt = 1'b1; // R14
            end
            if (req_in.wr && hit(req_in, laser_cfg_pkg::TBL_CTRL,
                                 laser_cfg_pkg::OFS_MOD_DAC)) begin
                mod_nxt = req_in.wdata; // R10
                mod_oe_nxt = 1'b1; // R15
            end
        end
    end

    // ----------------------------------------------------------------
    // Read data, interrupt and pin
    // ----------------------------------------------------------------
    always_comb begin
        rdata_nxt = 8'h00;
        rvalid_nxt = req_in.rd;
        if (req_in.rd) begin
            if (hit(req_in, laser_cfg_pkg::TBL_CTRL, laser_cfg_pkg::OFS_MODE)) begin
                rdata_nxt = mode_r; // R07
            end else if (hit(req_in, laser_cfg_pkg::TBL_CTRL,
                             laser_cfg_pkg::OFS_TEMP_INDEX)) begin
                rdata_nxt = index_r; // R13
            end else if (hit(req_in, laser_cfg_pkg::TBL_CTRL,
                             laser_cfg_pkg::OFS_BIAS_DAC)) begin
                rdata_nxt = bias_r;
            end else if (hit(req_in, laser_cfg_pkg::TBL_CTRL,
                             laser_cfg_pkg::OFS_MOD_DAC)) begin
                rdata_nxt = mod_r;
            end else if (hit(req_in, laser_cfg_pkg::TBL_CTRL,
                             laser_cfg_pkg::OFS_CONFIG)) begin
                rdata_nxt = config_r;
            end else if (hit(req_in, laser_cfg_pkg::TBL_MASKS,
                             laser_cfg_pkg::OFS_RSSI_WARN_MASK)) begin
                rdata_nxt = mask_r;
            end else if (lut_hit(req_in, laser_cfg_pkg::TBL_BIAS_LUT)) begin
                rdata_nxt = bias_lut[lut_addr];
            end else if (lut_hit(req_in, laser_cfg_pkg::TBL_MOD_LUT)) begin
                rdata_nxt = mod_lut[lut_addr];
            end
        end
        eff_mask = alt_mask_sel_in ? alt_rssi_mask_in : mask_r; // R04
        irq_nxt = other_irq_in
            | (eff_mask[laser_cfg_pkg::MASK_HI] & rssi_warn_in.high) // R01 R03
            | (eff_mask[laser_cfg_pkg::MASK_LO] & rssi_warn_in.low); // R02 R03
        gp_nxt = config_r[laser_cfg_pkg::CFG_INVERT]
            ^ (config_r[laser_cfg_pkg::CFG_SW_OUT] | hw_in_status_in); // R17 R18
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mode_r <= laser_cfg_pkg::MODE_RESET; // R07
            index_r <= laser_cfg_pkg::INDEX_RESET; // R13
            bias_r <= 8'h00;
            mod_r <= 8'h00;
            bias_oe_r <= 1'b0; // R14
            mod_oe_r <= 1'b0; // R15
            config_r <= laser_cfg_pkg::CONFIG_RESET;
            mask_r <= laser_cfg_pkg::MASK_RESET;
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
            irq_r <= 1'b0;
            gp_r <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            index_r <= index_nxt;
            bias_r <= bias_nxt;
            mod_r <= mod_nxt;
            bias_oe_r <= bias_oe_nxt;
            mod_oe_r <= mod_oe_nxt;
            config_r <= config_nxt;
            mask_r <= mask_nxt;
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            irq_r <= irq_nxt;
            gp_r <= gp_nxt;
        end
    end

    assign rdata_out = rdata_r;
    assign rvalid_out = rvalid_r;
    assign module_irq_status_out = irq_r;
    assign bias_dac_out = bias_r;
    assign bias_dac_oe_out = bias_oe_r;
    assign mod_dac_out = mod_r;
    assign mod_dac_oe_out = mod_oe_r;
    assign bias_dac_range_out = config_r[laser_cfg_pkg::CFG_BIAS_RANGE]; // R20
    assign mod_dac_range_out = config_r[laser_cfg_pkg::CFG_MOD_RANGE]; // R20
    assign gp_output_pin_out = gp_r;
    assign fast_trip_en_out = mode_r[laser_cfg_pkg::MODE_FT_EN]; // R08
    assign shadow_volatile_out = mode_r[laser_cfg_pkg::MODE_VOLATILE]; // R09
    assign temp_conv_en_out = mode_r[laser_cfg_pkg::MODE_TEMP_CONV]; // R10 R11
    assign trip_flag_latch_en_out = config_r[laser_cfg_pkg::CFG_TRIP_LATCH]; // R19
    assign alarm_latch_en_out = config_r[laser_cfg_pkg::CFG_ALARM_LATCH]; // R21
    assign warn_latch_en_out = config_r[laser_cfg_pkg::CFG_WARN_LATCH]; // R22
endmodule // laser_dac_lut_config_regs

// [pkg/laser_cfg_pkg.sv]
/*
 Constants, register map and carriers for the laser DAC lookup and
 configuration register bank.
 Assumes a simple synchronous byte-wide register port driven by the
 serial interface front end, which resolves the table select itself.
*/
// Notes on behaviour
// R01: Mask bit7 lets high warning raise interrupt
// R02: Mask bit6 lets low warning; bits5:0 reserved
// R03: Enabled warning flag sets interrupt status bit
// R04: Select bit picks this or alternate mask set
// R05: Bias lookup table 80h-C7h, defaults zero
// R06: Mod lookup table 80h-C7h, defaults zero
// R07: Mode resets to 0Bh, upper nibble zero
// R08: Mode bit3 enables fast-trip comparators
// R09: Mode bit2 makes shadowed memory volatile
// R10: Bit1 clear: no conversions, manual DAC writes
// R11: Bit1 set: conversions, DACs from tables
// R12: Bit0 clear: host writes index; else automatic
// R13: Index reads zero until first conversion
// R14: Bias DAC high-impedance until value recalled
// R15: Mod DAC high-impedance until value recalled
// R16: DAC bytes refreshed from table entry
// R17: Config bit7 software output term; bit6 unused
// R18: Output pin is OR of terms, optionally inverted
// R19: Config bit4 latches fast-trip flags
// R20: Config bits3/2 select DAC full-scale range
// R21: Config bit1 latches alarm flags
// R22: Config bit0 latches warning flags
// R23: Auto mode loads entry 80h plus index
// R24: Index clamped so entry stays within C7h
package laser_cfg_pkg;
    // ----------------------------------------------------------------
    // Table numbers and offsets
    // ----------------------------------------------------------------
    localparam logic [2:0] TBL_MASKS = 3'h1;
    localparam logic [2:0] TBL_BIAS_LUT = 3'h2;
    localparam logic [2:0] TBL_MOD_LUT = 3'h3;
    localparam logic [2:0] TBL_CTRL = 3'h4;
    localparam logic [2:0] TBL_ALT_MASKS = 3'h5;
    localparam logic [7:0] OFS_MODE = 8'h80;
    localparam logic [7:0] OFS_TEMP_INDEX = 8'h81;
    localparam logic [7:0] OFS_BIAS_DAC = 8'h82;
    localparam logic [7:0] OFS_MOD_DAC = 8'h83;
    localparam logic [7:0] OFS_CONFIG = 8'h88;
    localparam logic [7:0] OFS_RSSI_WARN_MASK = 8'hFB;
    localparam logic [7:0] OFS_LUT_FIRST = 8'h80;
    localparam logic [7:0] OFS_LUT_LAST = 8'hC7;
    localparam int LUT_DEPTH = 72;
    localparam logic [7:0] INDEX_MAX = 8'h47;
    // ----------------------------------------------------------------
    // Reset values and field positions
    // ----------------------------------------------------------------
    localparam logic [7:0] MODE_RESET = 8'h0B;
    localparam logic [7:0] MODE_WR_MASK = 8'h0F;
    localparam logic [7:0] INDEX_RESET = 8'h00;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] CONFIG_WR_MASK = 8'hBF;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] MASK_WR_MASK = 8'hC0;
    localparam logic [7:0] LUT_RESET = 8'h00;
    localparam int MODE_FT_EN = 3;
    localparam int MODE_VOLATILE = 2;
    localparam int MODE_TEMP_CONV = 1;
    localparam int MODE_AUTO_INDEX = 0;
    localparam int CFG_SW_OUT = 7;
    localparam int CFG_INVERT = 5;
    localparam int CFG_TRIP_LATCH = 4;
    localparam int CFG_MOD_RANGE = 3;
    localparam int CFG_BIAS_RANGE = 2;
    localparam int CFG_ALARM_LATCH = 1;
    localparam int CFG_WARN_LATCH = 0;
    localparam int MASK_HI = 7;
    localparam int MASK_LO = 6;

    // Register port request from the serial front end
    typedef struct packed {
        logic wr;
        logic rd;
        logic [2:0] table_sel;
        logic [7:0] offset;
        logic [7:0] wdata;
    } reg_req_s;

    // Warning flags of the RSSI monitor channel
    typedef struct packed {
        logic high;
        logic low;
    } rssi_warn_s;
endpackage

// [verif/laser_cfg_asserts.sv]
/*
 Checker for the port behaviour of the laser DAC register bank.
 Assumes it is bound onto laser_dac_lut_config_regs.
*/
`timescale 1ns/10ps
module laser_cfg_asserts (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire laser_cfg_pkg::reg_req_s req_in,
    input wire laser_cfg_pkg::rssi_warn_s rssi_warn_in,
    input wire logic other_irq_in,
    input wire logic alt_mask_sel_in,
    input wire logic [7:0] alt_rssi_mask_in,
    input wire logic [7:0] rdata_out,
    input wire logic rvalid_out,
    input wire logic module_irq_status_out,
    input wire logic [7:0] bias_dac_out,
    input wire logic bias_dac_oe_out,
    input wire logic fast_trip_en_out,
    input wire logic temp_conv_en_out,
    input wire logic bias_dac_range_out,
    input wire logic warn_latch_en_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence ctl_wr(logic [7:0] o);
        req_in.wr && req_in.table_sel == laser_cfg_pkg::TBL_CTRL && req_in.offset == o;
    endsequence
    sequence ctl_rd(logic [7:0] o);
        req_in.rd && req_in.table_sel == laser_cfg_pkg::TBL_CTRL && req_in.offset == o;
    endsequence
    chk_mode_upper: assert property (ctl_rd(laser_cfg_pkg::OFS_MODE) |=>
        rvalid_out && rdata_out[7:4] == 4'h0) else $error("mode upper bits set");
    chk_mode_bits: assert property (ctl_wr(laser_cfg_pkg::OFS_MODE) |=>
        fast_trip_en_out == $past(req_in.wdata[3]) && temp_conv_en_out == $past(req_in.wdata[1]))
        else $error("mode outputs wrong");
    chk_cfg_bits: assert property (ctl_wr(laser_cfg_pkg::OFS_CONFIG) |=>
        bias_dac_range_out == $past(req_in.wdata[2])
        && warn_latch_en_out == $past(req_in.wdata[0])) else $error("config outputs wrong");
    chk_manual_dac: assert property (ctl_wr(laser_cfg_pkg::OFS_BIAS_DAC)
        ##0 !temp_conv_en_out |=> bias_dac_out == $past(req_in.wdata) && bias_dac_oe_out)
        else $error("manual dac lost");
    chk_oe_sticks: assert property (bias_dac_oe_out |=> bias_dac_oe_out)
        else $error("dac drive dropped");
    chk_irq_high: assert property (alt_mask_sel_in && alt_rssi_mask_in[7]
        && rssi_warn_in.high |=> module_irq_status_out) else $error("irq missing");
    chk_irq_quiet: assert property (!other_irq_in && !rssi_warn_in.high && !rssi_warn_in.low
        |=> !module_irq_status_out) else $error("irq without cause");
    chk_alt_masked: assert property (alt_mask_sel_in && alt_rssi_mask_in[7:6] == 2'h0
        && !other_irq_in |=> !module_irq_status_out) else $error("masked irq raised");
endmodule // laser_cfg_asserts
bind laser_dac_lut_config_regs laser_cfg_asserts u_chk (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .req_in(req_in),
    .rssi_warn_in(rssi_warn_in),
    .other_irq_in(other_irq_in),
    .alt_mask_sel_in(alt_mask_sel_in),
    .alt_rssi_mask_in(alt_rssi_mask_in),
    .rdata_out(rdata_out),
    .rvalid_out(rvalid_out),
    .module_irq_status_out(module_irq_status_out),
    .bias_dac_out(bias_dac_out),
    .bias_dac_oe_out(bias_dac_oe_out),
    .fast_trip_en_out(fast_trip_en_out),
    .temp_conv_en_out(temp_conv_en_out),
    .bias_dac_range_out(bias_dac_range_out),
    .warn_latch_en_out(warn_latch_en_out)
);

// [verif/laser_host_model.sv]
/*
 Host side model issuing byte register requests.
 Assumes registered read data one cycle after the request edge.
*/
`timescale 1ns/10ps
module laser_host_model (
    input wire logic clk_in,
    output laser_cfg_pkg::reg_req_s req_out,
    input wire logic [7:0] rdata_in
);
    initial req_out = '0;
    task automatic access(input logic w, input logic [2:0] t, input logic [7:0] o,
        input logic [7:0] d, output logic [7:0] q);
        @(negedge clk_in);
        req_out = {w, !w, t, o, d};
        @(negedge clk_in);
        req_out = '0;
        q = rdata_in;
    endtask
endmodule // laser_host_model

// [verif/test_laser_dac_lut_config_regs.sv]
/*
 Self-checking bench for the laser DAC register bank.
 Assumes the checker is bound in and the host model drives requests.
*/
`timescale 1ns/10ps
module test_laser_dac_lut_config_regs;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    laser_cfg_pkg::reg_req_s req_in;
    laser_cfg_pkg::rssi_warn_s rssi_warn_in = '0;
    logic other_irq_in = 1'b0;
    logic alt_mask_sel_in = 1'b0;
    logic [7:0] alt_rssi_mask_in = 8'h00;
    logic hw_in_status_in = 1'b0;
    logic conv_done_in = 1'b0;
    logic [7:0] conv_index_in = 8'h00;
    logic [7:0] rdata_out, bias_dac_out, mod_dac_out;
    logic rvalid_out, module_irq_status_out, bias_dac_oe_out, mod_dac_oe_out;
    logic bias_dac_range_out, mod_dac_range_out, gp_output_pin_out, fast_trip_en_out;
    logic shadow_volatile_out, temp_conv_en_out, trip_flag_latch_en_out;
    logic alarm_latch_en_out, warn_latch_en_out;
    logic [31:0] seed = 32'h8E39;
    logic [31:0] v;
    logic [7:0] m, idx, e;
    logic [7:0] lut0[72];
    logic [7:0] lut1[72];
    int num_errors = 0;
    int num_checks = 0;
    laser_dac_lut_config_regs dut (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .req_in(req_in),
        .rssi_warn_in(rssi_warn_in),
        .other_irq_in(other_irq_in),
        .alt_mask_sel_in(alt_mask_sel_in),
        .alt_rssi_mask_in(alt_rssi_mask_in),
        .hw_in_status_in(hw_in_status_in),
        .conv_done_in(conv_done_in),
        .conv_index_in(conv_index_in),
        .rdata_out(rdata_out),
        .rvalid_out(rvalid_out),
        .module_irq_status_out(module_irq_status_out),
        .bias_dac_out(bias_dac_out),
        .bias_dac_oe_out(bias_dac_oe_out),
        .mod_dac_out(mod_dac_out),
        .mod_dac_oe_out(mod_dac_oe_out),
        .bias_dac_range_out(bias_dac_range_out),
        .mod_dac_range_out(mod_dac_range_out),
        .gp_output_pin_out(gp_output_pin_out),
        .fast_trip_en_out(fast_trip_en_out),
        .shadow_volatile_out(shadow_volatile_out),
        .temp_conv_en_out(temp_conv_en_out),
        .trip_flag_latch_en_out(trip_flag_latch_en_out),
        .alarm_latch_en_out(alarm_latch_en_out),
        .warn_latch_en_out(warn_latch_en_out)
    );
    laser_host_model hst (.clk_in(clk_in), .req_out(req_in), .rdata_in(rdata_out));
    initial forever #25 clk_in = ~clk_in;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wr(input logic [2:0] t, input logic [7:0] o, input logic [7:0] d);
        logic [7:0] q;
        hst.access(1'b1, t, o, d, q);
    endtask
    task automatic rd(input string n, input logic [2:0] t, input logic [7:0] o,
        input logic [7:0] x);
        logic [7:0] q;
        hst.access(1'b0, t, o, 8'h00, q);
        check(n, q, x);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        num_errors++;
        tally_and_finish();
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(negedge clk_in);
        rst_n_in = 1'b1;
        check("dac oe", {6'h0, bias_dac_oe_out, mod_dac_oe_out}, 8'h00);
        rd("mode", 3'h4, 8'h80, 8'h0B);
        rd("index", 3'h4, 8'h81, 8'h00);
        rd("mask", 3'h1, 8'hFB, 8'h00);
        for (int i = 0; i < 8; i++) begin
            v = rnd();
            hw_in_status_in = v[24];
            wr(3'h4, 8'h88, v[7:0]);
            rd("config", 3'h4, 8'h88, v[7:0] & 8'hBF);
            check("gp pin", {7'h0, gp_output_pin_out}, {7'h0, v[5] ^ (v[7] | v[24])});
            check("range", {6'h0, mod_dac_range_out, bias_dac_range_out}, {6'h0, v[3:2]});
            check("latch", {5'h0, trip_flag_latch_en_out, alarm_latch_en_out,
                warn_latch_en_out}, {5'h0, v[4], v[1:0]});
            wr(3'h4, 8'h80, v[15:8]);
            rd("mode", 3'h4, 8'h80, {4'h0, v[11:8]});
            check("mode outs", {5'h0, fast_trip_en_out, shadow_volatile_out,
                temp_conv_en_out}, {5'h0, v[11:9]});
            wr(3'h1, 8'hFB, v[23:16]);
            rd("mask", 3'h1, 8'hFB, v[23:16] & 8'hC0);
        end
        for (int i = 0; i < 16; i++) begin
            v = rnd();
            wr(3'h1, 8'hFB, v[7:0]);
            {alt_mask_sel_in, other_irq_in, rssi_warn_in} = v[11:8];
            alt_rssi_mask_in = v[23:16];
            repeat (2) @(negedge clk_in);
            m = v[11] ? v[23:16] : v[7:0];
            check("irq", {7'h0, module_irq_status_out},
                {7'h0, v[10] | (m[7] & v[9]) | (m[6] & v[8])});
        end
        {alt_mask_sel_in, other_irq_in, rssi_warn_in} = 4'h0;
        for (int i = 0; i < 72; i++) begin
            v = rnd();
            lut0[i] = v[7:0];
            lut1[i] = v[15:8];
            wr(3'h2, 8'h80 + 8'(i), v[7:0]);
            wr(3'h3, 8'h80 + 8'(i), v[15:8]);
        end
        rd("bias lut", 3'h2, 8'hC7, lut0[71]);
        rd("mod lut", 3'h3, 8'h80, lut1[0]);
        wr(3'h4, 8'h80, 8'h0B);
        for (int k = 0; k < 6; k++) begin
            v = rnd();
            idx = (k == 5) ? 8'hFF : {1'b0, v[6:0]};
            e = (idx > 8'h47) ? 8'h47 : idx;
            conv_index_in = idx;
            conv_done_in = 1'b1;
            @(negedge clk_in);
            conv_done_in = 1'b0;
            repeat (2) @(negedge clk_in);
            check("bias dac", bias_dac_out, lut0[e]);
            check("mod dac", mod_dac_out, lut1[e]);
            check("dac oe", {6'h0, bias_dac_oe_out, mod_dac_oe_out}, 8'h03);
            rd("index", 3'h4, 8'h81, e);
        end
        wr(3'h4, 8'h80, 8'h0A);
        wr(3'h4, 8'h81, 8'h60);
        rd("test index", 3'h4, 8'h81, 8'h47);
        wr(3'h4, 8'h81, 8'h05);
        rd("test index", 3'h4, 8'h81, 8'h05);
        check("test dac", bias_dac_out, lut0[5]);
        wr(3'h4, 8'h80, 8'h08);
        wr(3'h4, 8'h82, 8'h5A);
        wr(3'h4, 8'h83, 8'hA5);
        rd("manual bias", 3'h4, 8'h82, 8'h5A);
        check("manual mod", mod_dac_out, 8'hA5);
        wr(3'h4, 8'h80, 8'h0B);
        wr(3'h4, 8'h81, 8'h00);
        rd("locked index", 3'h4, 8'h81, 8'h05);
        wr(3'h4, 8'h82, 8'h33);
        rd("locked bias", 3'h4, 8'h82, lut0[5]);
        tally_and_finish();
    end
endmodule // test_laser_dac_lut_config_regs
